// ===== rtl/vbl_bias_table.sv
// Purpose: Writable oscillator bias lookup table with automatic application
// Assumes: Register port is driven synchronously by the serial front end
// Notes:   Core 1 ranges above band 63 hold no entry here; output then invalid
`timescale 1ns/100ps

module vbl_bias_table (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic [vbl_pkg::ADDR_W-1:0]   regAddr,
    input  wire logic                         regWrEn,
    input  wire logic [vbl_pkg::DATA_W-1:0]   regWrData,
    input  wire logic                         regRdEn,
    output logic      [vbl_pkg::DATA_W-1:0]   regRdData,
    input  wire logic [vbl_pkg::BAND_W-1:0]   calBand,
    input  wire logic                         calCore,
    output logic      [vbl_pkg::CODE_W-1:0]   biasCode,
    output logic                              biasValid
);
    logic [1:0]                       rstPipe_q;
    logic                             rstSync_n;
    logic [vbl_pkg::CODE_W-1:0]       entry_q [vbl_pkg::NUM_ENTRY];
    logic [vbl_pkg::BIN_W-1:0]        binIdx;
    logic                             wrHit;
    logic [vbl_pkg::IDX_W-1:0]        wrIdx;
    logic                             rdHit;
    logic [vbl_pkg::IDX_W-1:0]        rdIdx;
    logic                             lkHit;
    logic [vbl_pkg::IDX_W-1:0]        lkIdx;
    logic [vbl_pkg::DATA_W-1:0]       regRdData_q;
    logic [vbl_pkg::CODE_W-1:0]       biasCode_q;
    logic                             biasValid_q;

    // Register offset to table slot; used by both the write and read paths
    function automatic logic [4:0] addrDecode(input logic [vbl_pkg::ADDR_W-1:0] a);
        logic [vbl_pkg::ADDR_W-1:0] rel;
        rel = a - vbl_pkg::FIRST_CORE_BIAS_ENTRY_0;
        if (a >= vbl_pkg::FIRST_CORE_BIAS_ENTRY_0 && a <= vbl_pkg::SECOND_CORE_BIAS_ENTRY_2) begin
            addrDecode = {1'b1, rel[vbl_pkg::IDX_W-1:0]};
        end else begin
            addrDecode = 5'h00;
        end
    endfunction : addrDecode

    // Reset release through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe_q <= 2'b00;
        end else begin
            rstPipe_q <= {rstPipe_q[0], 1'b1};
        end
    end
    assign rstSync_n = rstPipe_q[1];

    assign {wrHit, wrIdx} = addrDecode(regAddr);
    assign {rdHit, rdIdx} = addrDecode(regAddr);

    // Table storage, one flop group per entry
    generate
        for (genvar g = 0; g < vbl_pkg::NUM_ENTRY; g++) begin : gEntry
            always_ff @(posedge clk or negedge rstSync_n) begin
                if (!rstSync_n) begin
                    entry_q[g] <= vbl_pkg::CODE_RESET;
                end else if (regWrEn && wrHit && wrIdx == vbl_pkg::IDX_W'(g)) begin
                    // Reserved bits are dropped at the write
                    entry_q[g] <= regWrData[vbl_pkg::CODE_LSB +: vbl_pkg::CODE_W];
                end
            end
        end
    endgenerate

    // Read path: data held until the next read; read before write in the same cycle
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            regRdData_q <= vbl_pkg::UNMAPPED_RD;
        end else if (regRdEn) begin
            if (rdHit) begin
                regRdData_q <= {2'b00, entry_q[rdIdx]};
            end else begin
                regRdData_q <= vbl_pkg::UNMAPPED_RD;
            end
        end
    end
    assign regRdData = regRdData_q;

    vbl_band_decode uBand (
        .bandIndex (calBand),
        .binIdx    (binIdx)
    );

    // Core 1 entries follow the nine core 0 entries
    always_comb begin
        lkHit = 1'b1;
        lkIdx = binIdx;
        if (calCore) begin
            lkHit = (binIdx < vbl_pkg::BIN_W'(vbl_pkg::CORE1_BINS));
            lkIdx = vbl_pkg::IDX_W'(binIdx + vbl_pkg::BIN_W'(vbl_pkg::CORE0_BINS));
        end
    end

    // Applied code is registered so the analog bias sees no decode glitches
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            biasCode_q  <= vbl_pkg::CODE_RESET;
            biasValid_q <= 1'b0;
        end else begin
            biasValid_q <= lkHit;
            if (lkHit) begin
                biasCode_q <= entry_q[lkIdx];
            end else begin
                biasCode_q <= vbl_pkg::CODE_RESET;
            end
        end
    end
    assign biasCode  = biasCode_q;
    assign biasValid = biasValid_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstSync_n);

    a_c0_bin0: assert property (!calCore && calBand < vbl_pkg::EDGE_1 |=> biasCode == $past(entry_q[0]))
        else $error("Core 0 range 0 code mismatch");
    a_c0_bin1: assert property (!calCore && calBand >= vbl_pkg::EDGE_1 && calBand < vbl_pkg::EDGE_2
        |=> biasCode == $past(entry_q[1]))
        else $error("Core 0 range 1 code mismatch");
    a_c0_bin2: assert property (!calCore && calBand >= vbl_pkg::EDGE_2 && calBand < vbl_pkg::EDGE_3
        |=> biasCode == $past(entry_q[2]))
        else $error("Core 0 range 2 code mismatch");
    a_c0_bin3: assert property (!calCore && calBand >= vbl_pkg::EDGE_3 && calBand < vbl_pkg::EDGE_4
        |=> biasCode == $past(entry_q[3]))
        else $error("Core 0 range 3 code mismatch");
    a_c0_bin4: assert property (!calCore && calBand >= vbl_pkg::EDGE_4 && calBand < vbl_pkg::EDGE_5
        |=> biasCode == $past(entry_q[4]))
        else $error("Core 0 range 4 code mismatch");
    a_c0_bin5: assert property (!calCore && calBand >= vbl_pkg::EDGE_5 && calBand < vbl_pkg::EDGE_6
        |=> biasCode == $past(entry_q[5]))
        else $error("Core 0 range 5 code mismatch");
    a_c0_bin6: assert property (!calCore && calBand >= vbl_pkg::EDGE_6 && calBand < vbl_pkg::EDGE_7
        |=> biasCode == $past(entry_q[6]))
        else $error("Core 0 range 6 code mismatch");
    a_c0_bin7: assert property (!calCore && calBand >= vbl_pkg::EDGE_7 && calBand < vbl_pkg::EDGE_8
        |=> biasCode == $past(entry_q[7]))
        else $error("Core 0 range 7 code mismatch");
    a_c0_bin8: assert property (!calCore && calBand >= vbl_pkg::EDGE_8 |=> biasCode == $past(entry_q[8]))
        else $error("Core 0 range 8 code mismatch");
    a_c1_bin0: assert property (calCore && calBand < vbl_pkg::EDGE_1
        |=> biasValid && biasCode == $past(entry_q[9]))
        else $error("Core 1 range 0 code mismatch");
    a_c1_bin1: assert property (calCore && calBand >= vbl_pkg::EDGE_1 && calBand < vbl_pkg::EDGE_2
        |=> biasValid && biasCode == $past(entry_q[10]))
        else $error("Core 1 range 1 code mismatch");
    a_c1_bin2: assert property (calCore && calBand >= vbl_pkg::EDGE_2 && calBand < vbl_pkg::EDGE_3
        |=> biasValid && biasCode == $past(entry_q[11]))
        else $error("Core 1 range 2 code mismatch");
    a_c1_uncovered: assert property (calCore && calBand >= vbl_pkg::EDGE_3 |=> !biasValid)
        else $error("Core 1 upper band wrongly valid");
    a_write_read_back: assert property (regWrEn && wrHit
        ##1 regRdEn && $past(regAddr) == regAddr && !regWrEn
        |=> regRdData == {2'b00, $past(regWrData[5:0], 2)})
        else $error("Written code not read back");
    a_reserved_zero: assert property (regRdData[7:6] == 2'b00)
        else $error("Reserved bits read nonzero");
    a_reset_clear: assert property ($rose(rstSync_n) |-> entry_q[0] == vbl_pkg::CODE_RESET
        && entry_q[11] == vbl_pkg::CODE_RESET && regRdData == vbl_pkg::UNMAPPED_RD)
        else $error("Table not cleared by reset");

    c_write_entry: cover property (regWrEn && wrHit);
    c_core1_valid: cover property (calCore && calBand < vbl_pkg::EDGE_3);
    c_core0_top: cover property (!calCore && calBand >= vbl_pkg::EDGE_8);
    c_write_then_read: cover property (regWrEn && wrHit ##1 regRdEn && rdHit);
endmodule : vbl_bias_table

// ===== rtl/vbl_pkg.sv
// Purpose: Shared constants for the oscillator bias lookup table
// Assumes: Byte-wide register port fed by the serial interface
// Notes:   Offsets are the serial register addresses
package vbl_pkg;
    localparam int ADDR_W     = 12;
    localparam int DATA_W     = 8;
    localparam int CODE_W     = 6;
    localparam int BAND_W     = 9;
    localparam int BIN_W      = 4;
    localparam int IDX_W      = 4;
    localparam int CORE0_BINS = 9;
    localparam int CORE1_BINS = 3;
    localparam int NUM_ENTRY  = CORE0_BINS + CORE1_BINS;

    // Register offsets, core 0 entries first, then core 1
    localparam logic [11:0] FIRST_CORE_BIAS_ENTRY_0  = 12'h100;
    localparam logic [11:0] FIRST_CORE_BIAS_ENTRY_1  = 12'h101;
    localparam logic [11:0] FIRST_CORE_BIAS_ENTRY_2  = 12'h102;
    localparam logic [11:0] FIRST_CORE_BIAS_ENTRY_3  = 12'h103;
    localparam logic [11:0] FIRST_CORE_BIAS_ENTRY_4  = 12'h104;
    localparam logic [11:0] FIRST_CORE_BIAS_ENTRY_5  = 12'h105;
    localparam logic [11:0] FIRST_CORE_BIAS_ENTRY_6  = 12'h106;
    localparam logic [11:0] FIRST_CORE_BIAS_ENTRY_7  = 12'h107;
    localparam logic [11:0] FIRST_CORE_BIAS_ENTRY_8  = 12'h108;
    localparam logic [11:0] SECOND_CORE_BIAS_ENTRY_0 = 12'h109;
    localparam logic [11:0] SECOND_CORE_BIAS_ENTRY_1 = 12'h10A;
    localparam logic [11:0] SECOND_CORE_BIAS_ENTRY_2 = 12'h10B;

    // Bias code field sits in bits [5:0], bits [7:6] are reserved
    localparam int          CODE_LSB   = 0;
    localparam logic [5:0]  CODE_RESET = 6'h00;
    localparam logic [7:0]  UNMAPPED_RD = 8'h00;

    // Lower edges of band ranges 1..8; range 0 starts at band 0
    localparam logic [8:0] EDGE_1 = 9'h010;
    localparam logic [8:0] EDGE_2 = 9'h020;
    localparam logic [8:0] EDGE_3 = 9'h040;
    localparam logic [8:0] EDGE_4 = 9'h080;
    localparam logic [8:0] EDGE_5 = 9'h0C0;
    localparam logic [8:0] EDGE_6 = 9'h100;
    localparam logic [8:0] EDGE_7 = 9'h140;
    localparam logic [8:0] EDGE_8 = 9'h1A0;
    localparam logic [8:0] BAND_EDGES [1:8] = '{EDGE_1, EDGE_2, EDGE_3, EDGE_4,
                                                EDGE_5, EDGE_6, EDGE_7, EDGE_8};
endpackage : vbl_pkg

// ===== rtl/vbl_band_decode.sv
// Purpose: Maps a 9-bit band index onto its bias table range
// Assumes: Band edges are ascending
// Notes:   Purely combinational
`timescale 1ns/100ps
module vbl_band_decode (
    input  wire logic [vbl_pkg::BAND_W-1:0] bandIndex,
    output logic      [vbl_pkg::BIN_W-1:0]  binIdx
);
    // Count the edges at or below the band: gives the range number directly
    always_comb begin
        binIdx = '0;
        for (int k = 1; k <= 8; k++) begin
            if (bandIndex >= vbl_pkg::BAND_EDGES[k]) begin
                binIdx = vbl_pkg::BIN_W'(k);
            end
        end
    end
endmodule : vbl_band_decode

// ===== verif/testbench.sv
// Purpose: Self-checking bench for the oscillator bias lookup table
// Assumes: Strobed register port and level lookup inputs, all driven on rising edges
// Notes:   Lookup checks wait an extra edge, harmless since the output is refreshed every cycle
`timescale 1ns/100ps
module testbench;
    logic                         clk = 1'b0;
    logic                         rst_n = 1'b0;
    logic [vbl_pkg::ADDR_W-1:0]   regAddr = '0;
    logic                         regWrEn = 1'b0;
    logic [vbl_pkg::DATA_W-1:0]   regWrData = '0;
    logic                         regRdEn = 1'b0;
    logic [vbl_pkg::DATA_W-1:0]   regRdData;
    logic [vbl_pkg::BAND_W-1:0]   calBand = '0;
    logic                         calCore = 1'b0;
    logic [vbl_pkg::CODE_W-1:0]   biasCode;
    logic                         biasValid;
    int                           badCount = 0;
    int                           testsRun = 0;
    int                           cycles = 0;
    logic [7:0]                   rdVal;

    vbl_bias_table dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
        .regRdEn(regRdEn), .regRdData(regRdData), .calBand(calBand), .calCore(calCore), .biasCode(biasCode),
        .biasValid(biasValid));

    always #5 clk = ~clk;

    // Whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            badCount = badCount + 1;
            print_verdict();
        end
    end

    function automatic logic [5:0] codeOf(input int i);
        return 6'(i * 7 + 5);
    endfunction : codeOf

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr   <= a;
        regWrData <= d;
        regWrEn   <= 1'b1;
        @(posedge clk);
        regWrEn   <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1 d = regRdData;
    endtask : rd

    // Write strobe followed at once by a read of the same address
    task automatic wr_rd(input logic [11:0] a, input logic [7:0] wd, output logic [7:0] d);
        @(posedge clk);
        regAddr   <= a;
        regWrData <= wd;
        regWrEn   <= 1'b1;
        @(posedge clk);
        regWrEn   <= 1'b0;
        regRdEn   <= 1'b1;
        @(posedge clk);
        regRdEn   <= 1'b0;
        #1 d = regRdData;
    endtask : wr_rd

    task automatic chk_reg(input string name, input logic [7:0] exp, input logic [7:0] got);
        testsRun = testsRun + 1;
        if (got !== exp) begin
            badCount = badCount + 1;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_reg

    task automatic chk_bias(input string name, input logic [5:0] expCode, input logic expValid);
        testsRun = testsRun + 1;
        if (biasCode !== expCode || biasValid !== expValid) begin
            badCount = badCount + 1;
            $display("MISMATCH %s expected %h/%b seen %h/%b", name, expCode, expValid, biasCode, biasValid);
        end
    endtask : chk_bias

    // Both edges of a range, so an edge decoded one band off shows up
    task automatic lookup(input logic core, input logic [8:0] lo, input logic [8:0] hi,
                          input logic [5:0] code, input logic vld);
        logic [8:0] b [2];
        b[0] = lo;
        b[1] = hi;
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            calCore <= core;
            calBand <= b[k];
            repeat (2) @(posedge clk);
            #1 chk_bias($sformatf("bias core %0d band %0d", core, b[k]), code, vld);
        end
    endtask : lookup

    task automatic print_verdict();
        $display("Counts: %0d comparisons, %0d mismatches", testsRun, badCount);
        if (badCount == 0 && testsRun > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < vbl_pkg::NUM_ENTRY; i++) begin
            rd(vbl_pkg::FIRST_CORE_BIAS_ENTRY_0 + 12'(i), rdVal);
            chk_reg($sformatf("reset entry %0d", i), 8'h00, rdVal);
        end
        lookup(1'b0, 9'h000, 9'h1A0, 6'h00, 1'b1);
        $display("Test reset values done");
        // Upper bits set on every table entry write to prove they are dropped
        for (int i = 0; i < vbl_pkg::NUM_ENTRY; i++)
            wr(vbl_pkg::FIRST_CORE_BIAS_ENTRY_0 + 12'(i), {2'b11, codeOf(i)});
        wr(12'h10C, 8'h3F);
        wr(12'h0FF, 8'h3F);
        for (int i = 0; i < vbl_pkg::NUM_ENTRY; i++) begin
            rd(vbl_pkg::FIRST_CORE_BIAS_ENTRY_0 + 12'(i), rdVal);
            chk_reg($sformatf("entry %0d", i), {2'b00, codeOf(i)}, rdVal);
        end
        rd(12'h10C, rdVal);
        chk_reg("unmapped 10C", 8'h00, rdVal);
        rd(12'h0FF, rdVal);
        chk_reg("unmapped 0FF", 8'h00, rdVal);
        $display("Test register access done");
        lookup(1'b0, 9'h000, 9'h00F, codeOf(0), 1'b1);
        lookup(1'b0, 9'h010, 9'h01F, codeOf(1), 1'b1);
        lookup(1'b0, 9'h020, 9'h03F, codeOf(2), 1'b1);
        lookup(1'b0, 9'h040, 9'h07F, codeOf(3), 1'b1);
        lookup(1'b0, 9'h080, 9'h0BF, codeOf(4), 1'b1);
        lookup(1'b0, 9'h0C0, 9'h0FF, codeOf(5), 1'b1);
        lookup(1'b0, 9'h100, 9'h13F, codeOf(6), 1'b1);
        lookup(1'b0, 9'h140, 9'h19F, codeOf(7), 1'b1);
        lookup(1'b0, 9'h1A0, 9'h1FF, codeOf(8), 1'b1);
        lookup(1'b1, 9'h000, 9'h00F, codeOf(9), 1'b1);
        lookup(1'b1, 9'h010, 9'h01F, codeOf(10), 1'b1);
        lookup(1'b1, 9'h020, 9'h03F, codeOf(11), 1'b1);
        lookup(1'b1, 9'h040, 9'h1FF, 6'h00, 1'b0);
        wr(vbl_pkg::SECOND_CORE_BIAS_ENTRY_2, 8'h2A);
        lookup(1'b1, 9'h020, 9'h03F, 6'h2A, 1'b1);
        wr_rd(vbl_pkg::FIRST_CORE_BIAS_ENTRY_3, 8'hEA, rdVal);
        chk_reg("write then read entry 3", 8'h2A, rdVal);
        lookup(1'b0, 9'h040, 9'h07F, 6'h2A, 1'b1);
        $display("Test band lookup done");
        print_verdict();
    end
endmodule : testbench
